// >>> bench/iff_core_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Core side: takes each active-low request line as a level
// ----------------------------------------------------------------
module iff_core_model (
    input wire clk,
    input wire rst,
    input wire normalLineN,
    input wire fastLineN,
    output logic normalTaken,
    output logic fastTaken
);
    // One flop of delay, as a core samples its request pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            normalTaken <= 1'b0;
            fastTaken <= 1'b0;
        end else begin
            normalTaken <= ~normalLineN;
            fastTaken <= ~fastLineN;
        end
    end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic nLineN, fLineN, protectionMode, normalTaken, fastTaken;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, srcIn, rd;
    int numErrors = 0;
    int samplesChecked = 0;

    iff_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .srcIn(srcIn), .normal_interrupt_line_n(nLineN),
        .fast_interrupt_line_n(fLineN), .protectionMode(protectionMode));
    iff_core_model core (.clk(clk), .rst(rst), .normalLineN(nLineN), .fastLineN(fLineN),
        .normalTaken(normalTaken), .fastTaken(fastTaken));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task summarize;
        $display("checked %0d errors %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            numErrors++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    // Read just after an edge, design outputs still show what that edge sampled
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) check("pready", 32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rdChk(input string name, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask
    // Sources pass two sync flops and a route flop before the lines move
    task settle;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask
    task lines(input logic expN, input logic expF);
        check("normal", {31'h0, normalTaken}, {31'h0, expN});
        check("fast", {31'h0, fastTaken}, {31'h0, expF});
        rdChk("lsr", iff_pkg::OFS_LINE_STATUS, {30'h0, expN, expF});
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge clk);
        numErrors++;
        summarize;
    end
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        srcIn = 32'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdChk("dbg", iff_pkg::OFS_DEBUG_CONTROL, 32'h0);
        check("protection_mode_bit", {31'h0, protectionMode}, 32'h0);
        rdChk("ffs", iff_pkg::OFS_FF_STATE, 32'h0);
        wr(iff_pkg::OFS_DEBUG_CONTROL, 32'h1);
        @(negedge clk);
        check("protection_mode_bit", {31'h0, protectionMode}, 32'h1);
        rdChk("dbg", iff_pkg::OFS_DEBUG_CONTROL, 32'h1);
        wr(iff_pkg::OFS_DEBUG_CONTROL, 32'h2);
        @(negedge clk);
        check("protection_mode_bit", {31'h0, protectionMode}, 32'h0);
        rdChk("dbg", iff_pkg::OFS_DEBUG_CONTROL, 32'h2);
        wr(iff_pkg::OFS_DEBUG_CONTROL, 32'h0);
        wr(iff_pkg::OFS_FF_ENABLE, 32'hffff_ffff);
        rdChk("ffs", iff_pkg::OFS_FF_STATE, 32'hffff_fffe);
        wr(iff_pkg::OFS_FF_DISABLE, 32'h0000_00f1);
        rdChk("ffs", iff_pkg::OFS_FF_STATE, 32'hffff_ff0e);
        wr(iff_pkg::OFS_FF_ENABLE, 32'h0);
        rdChk("ffs", iff_pkg::OFS_FF_STATE, 32'hffff_ff0e);
        wr(iff_pkg::OFS_FF_ENABLE, 32'h0000_0031);
        rdChk("ffs", iff_pkg::OFS_FF_STATE, 32'hffff_ff3e);
        rdChk("ffe", iff_pkg::OFS_FF_ENABLE, 32'h0);
        wr(iff_pkg::OFS_FF_STATE, 32'h0);
        rdChk("ffs", iff_pkg::OFS_FF_STATE, 32'hffff_ff3e);
        wr(iff_pkg::OFS_FF_DISABLE, 32'hffff_ffff);
        rdChk("ffs", iff_pkg::OFS_FF_STATE, 32'h0);
        xfer(1'b0, 8'h20, 32'h0);
        check("slverr", {31'h0, err}, 32'h1);
        check("unmapped", rd, 32'h0);
        wr(iff_pkg::OFS_SRC_MASK, 32'hffff_ffff);
        srcIn <= 32'h4;
        settle;
        lines(1'b1, 1'b0);
        wr(iff_pkg::OFS_FF_ENABLE, 32'h4);
        settle;
        lines(1'b0, 1'b1);
        wr(iff_pkg::OFS_DEBUG_CONTROL, 32'h2);
        settle;
        lines(1'b0, 1'b0);
        wr(iff_pkg::OFS_DEBUG_CONTROL, 32'h0);
        wr(iff_pkg::OFS_FF_DISABLE, 32'h4);
        settle;
        lines(1'b1, 1'b0);
        srcIn <= 32'h1;
        settle;
        lines(1'b0, 1'b1);
        summarize;
    end
endmodule

// >>> rtl/iff_pkg.sv
package iff_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_DEBUG_CONTROL = 8'h00;
    localparam logic [7:0] OFS_FF_ENABLE = 8'h04;
    localparam logic [7:0] OFS_FF_DISABLE = 8'h08;
    localparam logic [7:0] OFS_FF_STATE = 8'h0c;
    localparam logic [7:0] OFS_SRC_MASK = 8'h10;
    localparam logic [7:0] OFS_LINE_STATUS = 8'h14;
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int BIT_PROTECTION = 0;
    localparam int BIT_GENERAL_MASK = 1;
    localparam int BIT_FAST_SRC = 0;
    localparam int BIT_NORMAL_LINE = 1;
    localparam int BIT_FAST_LINE = 0;
    localparam logic [31:0] FF_IMPL_MASK = 32'hffff_fffe;
    localparam logic [1:0] RST_DEBUG_CONTROL = 2'h0;
    localparam logic [31:0] RST_FF_STATE = 32'h0000_0000;
    localparam logic [31:0] RST_SRC_MASK = 32'h0000_0000;
    localparam int NUM_SRC = 32;

    typedef enum {
        APB_IDLE,
        APB_ACCESS
    } iff_apb_state_t;
endpackage

// >>> rtl/iff_route.sv
`timescale 1ns/100ps
module iff_route (
    input wire clk,
    input wire rst,
    iff_route_if.route rt
);
    logic [31:0] toFast;
    logic [31:0] toNormal;
    logic normalReq_r;
    logic fastReq_r;

    // ----------------------------------------------------------------
    // Per-source steering
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < iff_pkg::NUM_SRC; i++) begin : g_src
            if (i == iff_pkg::BIT_FAST_SRC) begin : g_fast
                assign toFast[i] = rt.srcActive[i];
                assign toNormal[i] = 1'b0;
            end else begin : g_other
                assign toFast[i] = rt.srcActive[i] & rt.fastForce[i];
                assign toNormal[i] = rt.srcActive[i] & ~rt.fastForce[i];
            end
        end
    endgenerate

    // Registered so the core lines never glitch on decode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            normalReq_r <= 1'b0;
            fastReq_r <= 1'b0;
        end else begin
            normalReq_r <= (|toNormal) & ~rt.generalMask;
            fastReq_r <= (|toFast) & ~rt.generalMask;
        end
    end

    assign rt.normalReq = normalReq_r;
    assign rt.fastReq = fastReq_r;

    a_mask_holds_lines: assert property (@(posedge clk) disable iff (rst)
        rt.generalMask |=> (!normalReq_r && !fastReq_r))
        else $error("Request active under general mask");
endmodule

// >>> rtl/iff_route_if.sv
`timescale 1ns/100ps
interface iff_route_if;
    logic [31:0] srcActive;
    logic [31:0] fastForce;
    logic generalMask;
    logic normalReq;
    logic fastReq;
    modport ctrl (output srcActive, output fastForce, output generalMask,
        input normalReq, input fastReq);
    modport route (input srcActive, input fastForce, input generalMask,
        output normalReq, output fastReq);
endinterface

// >>> rtl/iff_top.sv
// Summary of operation
// - General mask set holds both interrupt lines inactive.
// - Protection bit enables protection mode; control register resets to zero.
// - Enable command sets fast forcing where written one; zeros ignored.
// - Disable command clears fast forcing where written one; zeros ignored.
// - Status register reads one per source with fast forcing enabled.
// - Fast forcing only on bits 1 to 31; bit 0 unimplemented.
`timescale 1ns/100ps
module iff_top (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire [31:0] srcIn,
    output logic normal_interrupt_line_n,
    output logic fast_interrupt_line_n,
    output logic protectionMode
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [1:0] debugControl_r;
    logic [31:0] fastForce_r;
    logic [31:0] srcMask_r;
    logic [31:0] srcSync1_r;
    logic [31:0] srcSync2_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    iff_pkg::iff_apb_state_t apbState_r;
    logic wrStrobe;
    logic rdStrobe;
    logic addrOk;
    logic [31:0] rdValue;
    iff_route_if rtIf();

    // ----------------------------------------------------------------
    // APB slave: one wait state, answer in the second access cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            apbState_r <= iff_pkg::APB_IDLE;
        end else begin
            case (apbState_r)
                iff_pkg::APB_IDLE: begin
                    if (psel && penable) begin
                        apbState_r <= iff_pkg::APB_ACCESS;
                    end
                end
                iff_pkg::APB_ACCESS: begin
                    apbState_r <= iff_pkg::APB_IDLE;
                end
                default: begin
                    apbState_r <= iff_pkg::APB_IDLE;
                end
            endcase
        end
    end

    assign pready = (apbState_r == iff_pkg::APB_ACCESS);
    assign wrStrobe = psel && penable && pready && pwrite;
    assign rdStrobe = psel && penable && !pwrite;

    always_comb begin
        addrOk = 1'b1;
        rdValue = 32'h0000_0000;
        case (paddr)
            iff_pkg::OFS_DEBUG_CONTROL: begin
                rdValue[1:0] = debugControl_r;
            end
            iff_pkg::OFS_FF_ENABLE: begin
                rdValue = 32'h0000_0000;
            end
            iff_pkg::OFS_FF_DISABLE: begin
                rdValue = 32'h0000_0000;
            end
            iff_pkg::OFS_FF_STATE: begin
                rdValue = fastForce_r & iff_pkg::FF_IMPL_MASK;
            end
            iff_pkg::OFS_SRC_MASK: begin
                rdValue = srcMask_r;
            end
            iff_pkg::OFS_LINE_STATUS: begin
                rdValue[iff_pkg::BIT_NORMAL_LINE] = rtIf.normalReq;
                rdValue[iff_pkg::BIT_FAST_LINE] = rtIf.fastReq;
            end
            default: begin
                addrOk = 1'b0;
            end
        endcase
    end

    // Read data captured in the wait cycle, stable when pready rises
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata_r <= rdStrobe ? rdValue : 32'h0000_0000;
            pslverr_r <= !addrOk;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pready ? pslverr_r : 1'b0;

    // ----------------------------------------------------------------
    // Debug control
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            debugControl_r <= iff_pkg::RST_DEBUG_CONTROL;
        end else if (wrStrobe && paddr == iff_pkg::OFS_DEBUG_CONTROL) begin
            debugControl_r <= pwdata[1:0];
        end
    end

    assign protectionMode = debugControl_r[iff_pkg::BIT_PROTECTION];

    // ----------------------------------------------------------------
    // Fast forcing state
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fastForce_r <= iff_pkg::RST_FF_STATE;
        end else if (wrStrobe && paddr == iff_pkg::OFS_FF_ENABLE) begin
            fastForce_r <= (fastForce_r | pwdata) & iff_pkg::FF_IMPL_MASK;
        end else if (wrStrobe && paddr == iff_pkg::OFS_FF_DISABLE) begin
            fastForce_r <= fastForce_r & ~pwdata & iff_pkg::FF_IMPL_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            srcMask_r <= iff_pkg::RST_SRC_MASK;
        end else if (wrStrobe && paddr == iff_pkg::OFS_SRC_MASK) begin
            srcMask_r <= pwdata;
        end
    end

    // Sources arrive from other logic blocks; synchronised as pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            srcSync1_r <= 32'h0000_0000;
            srcSync2_r <= 32'h0000_0000;
        end else begin
            srcSync1_r <= srcIn;
            srcSync2_r <= srcSync1_r;
        end
    end

    // ----------------------------------------------------------------
    // Routing to the core lines
    // ----------------------------------------------------------------
    assign rtIf.srcActive = srcSync2_r & srcMask_r;
    assign rtIf.fastForce = fastForce_r;
    assign rtIf.generalMask = debugControl_r[iff_pkg::BIT_GENERAL_MASK];

    iff_route u_route (
        .clk(clk),
        .rst(rst),
        .rt(rtIf.route)
    );

    // Lines are active low toward the core
    assign normal_interrupt_line_n = ~rtIf.normalReq;
    assign fast_interrupt_line_n = ~rtIf.fastReq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_ff_set_write;
        wrStrobe && paddr == iff_pkg::OFS_FF_ENABLE;
    endsequence

    sequence s_ff_clr_write;
        wrStrobe && paddr == iff_pkg::OFS_FF_DISABLE;
    endsequence

    a_ff_enable_sets: assert property (@(posedge clk) disable iff (rst)
        s_ff_set_write |=> ((fastForce_r & ($past(pwdata) & iff_pkg::FF_IMPL_MASK))
            == ($past(pwdata) & iff_pkg::FF_IMPL_MASK)))
        else $error("Enable command did not set bits");

    a_ff_enable_keeps: assert property (@(posedge clk) disable iff (rst)
        s_ff_set_write |=> ((fastForce_r & ~$past(pwdata)) == ($past(fastForce_r) & ~$past(pwdata))))
        else $error("Enable command changed zero bits");

    a_ff_disable_clears: assert property (@(posedge clk) disable iff (rst)
        s_ff_clr_write |=> ((fastForce_r & $past(pwdata)) == 32'h0000_0000))
        else $error("Disable command did not clear bits");

    a_ff_disable_keeps: assert property (@(posedge clk) disable iff (rst)
        s_ff_clr_write |=> ((fastForce_r & ~$past(pwdata)) == ($past(fastForce_r) & ~$past(pwdata))))
        else $error("Disable command changed zero bits");

    a_ff_bit0_zero: assert property (@(posedge clk) disable iff (rst)
        !fastForce_r[iff_pkg::BIT_FAST_SRC])
        else $error("Fast forcing bit 0 set");

    a_ff_status_read: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && !pwrite && !pready && paddr == iff_pkg::OFS_FF_STATE)
        |=> (prdata == $past(fastForce_r)))
        else $error("Status read mismatch");

    a_protection_mode_bit_follows: assert property (@(posedge clk) disable iff (rst)
        (wrStrobe && paddr == iff_pkg::OFS_DEBUG_CONTROL)
        |=> (protectionMode == $past(pwdata[iff_pkg::BIT_PROTECTION])))
        else $error("Protection mode not following write");

    a_gen_mask_lines: assert property (@(posedge clk) disable iff (rst)
        rtIf.generalMask[*2] |-> (normal_interrupt_line_n && fast_interrupt_line_n))
        else $error("Line active under general mask");

    a_forced_to_fast: assert property (@(posedge clk) disable iff (rst)
        (!rtIf.generalMask && (rtIf.srcActive & fastForce_r) != 32'h0000_0000)
        |=> !fast_interrupt_line_n)
        else $error("Forced source missed fast line");
endmodule
